// *** shared/crs_pkg.sv ***
// package: timing, sfr map and reset patterns for the reset sequencer
`default_nettype none
package crs_pkg;
  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  localparam int unsigned PHASES_PER_CYCLE = 12;
  localparam logic [3:0]  PHASE_FIRST      = 4'h0;
  localparam logic [3:0]  PHASE_LAST       = 4'hb;
  localparam logic [3:0]  PHASE_SAMPLE     = 4'h9;
  localparam logic [3:0]  ALE_ON_A         = 4'h1;
  localparam logic [3:0]  ALE_OFF_A        = 4'h3;
  localparam logic [3:0]  ALE_ON_B         = 4'h7;
  localparam logic [3:0]  ALE_OFF_B        = 4'h9;
  localparam logic [3:0]  PROGRAM_STORE_READ_STROBE_LO_A        = 4'h4;
  localparam logic [3:0]  PROGRAM_STORE_READ_STROBE_HI_A        = 4'h6;
  localparam logic [3:0]  PROGRAM_STORE_READ_STROBE_LO_B        = 4'ha;
  localparam logic [3:0]  PROGRAM_STORE_READ_STROBE_HI_B        = 4'hc;
  // clk is the oscillator itself
  localparam int unsigned CLK_PER_OSC      = 1;
  localparam int unsigned PORT_HOLD_OSC    = 19;
  localparam int unsigned PORT_HOLD_CYC    = PORT_HOLD_OSC * CLK_PER_OSC;
  localparam logic [4:0]  HOLD_LOAD        = 5'(PORT_HOLD_CYC);
  localparam logic [4:0]  HOLD_DONE        = 5'h00;
  localparam logic [4:0]  HOLD_STEP        = 5'h01;
  localparam logic [3:0]  PHASE_STEP       = 4'h1;

  typedef logic [3:0] crs_phase_t;
  typedef logic [4:0] crs_hold_t;
  typedef logic [4:0] crs_sfr_idx_t;
  typedef logic [3:0] crs_ram_idx_t;
  typedef logic [7:0] crs_byte_t;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_PEND  = 2'b01,
    ST_RESET = 2'b10
  } crs_state_t;

  // ----------------------------------------
  // special function register index map
  // ----------------------------------------
  localparam int unsigned SFR_COUNT = 27;
  localparam int unsigned RAM_COUNT = 16;
  localparam crs_sfr_idx_t IDX_PCL = 5'h00, IDX_PCH = 5'h01, IDX_ACC = 5'h02;
  localparam crs_sfr_idx_t IDX_B   = 5'h03, IDX_PSW = 5'h04, IDX_SP  = 5'h05;
  localparam crs_sfr_idx_t IDX_DPL = 5'h06, IDX_DPH = 5'h07, IDX_P0  = 5'h08;
  localparam crs_sfr_idx_t IDX_P3  = 5'h0b, IDX_IP  = 5'h0c, IDX_IE  = 5'h0d;
  localparam crs_sfr_idx_t IDX_T2_FIRST = 5'h14, IDX_T2_LAST = 5'h17;
  localparam crs_sfr_idx_t IDX_SERIAL_CONTROL_REGISTER = 5'h18, IDX_SERIAL_BUFFER = 5'h19, IDX_POWER_CONTROL_REGISTER = 5'h1a;

  localparam crs_byte_t VAL_ZERO      = 8'h00;
  localparam crs_byte_t VAL_PORT      = 8'hff;
  localparam crs_byte_t VAL_SP        = 8'h07;
  localparam crs_byte_t MASK_ALL      = 8'hff;
  localparam crs_byte_t MASK_NONE     = 8'h00;
  localparam crs_byte_t MASK_IP_BASE  = 8'h1f;
  localparam crs_byte_t MASK_IP_3T    = 8'h3f;
  localparam crs_byte_t MASK_IE_BASE  = 8'h9f;
  localparam crs_byte_t MASK_IE_3T    = 8'hbf;
  localparam crs_byte_t MASK_POWER_CONTROL_REGISTER     = 8'h80;
  localparam crs_byte_t MASK_POWER_CONTROL_REGISTER_LP  = 8'h8f;

  function automatic crs_byte_t reset_value(crs_sfr_idx_t idx);
    if (idx >= IDX_P0 && idx <= IDX_P3)
      return VAL_PORT;
    return (idx == IDX_SP) ? VAL_SP : VAL_ZERO;
  endfunction

  // set bits are forced, others keep whatever they held
  function automatic crs_byte_t reset_mask(crs_sfr_idx_t idx, logic three_t, logic low_pwr);
    if (idx == IDX_SERIAL_BUFFER)
      return MASK_NONE;
    if (idx == IDX_IP)
      return three_t ? MASK_IP_3T : MASK_IP_BASE;
    if (idx == IDX_IE)
      return three_t ? MASK_IE_3T : MASK_IE_BASE;
    if (idx == IDX_POWER_CONTROL_REGISTER)
      return low_pwr ? MASK_POWER_CONTROL_REGISTER_LP : MASK_POWER_CONTROL_REGISTER;
    if (idx >= IDX_T2_FIRST && idx <= IDX_T2_LAST)
      return three_t ? MASK_ALL : MASK_NONE;
    return MASK_ALL;
  endfunction
endpackage
`default_nettype wire

// *** shared/crs_timing_if.sv ***
// interface: machine cycle phase and strobe pattern
`default_nettype none
interface crs_timing_if;
  logic [3:0] phase;
  logic       sample_point;
  logic       cycle_end;
  logic       ale;
  logic       program_store_read_strobe_n;
  modport gen (output phase, output sample_point, output cycle_end, output ale, output program_store_read_strobe_n);
  modport sink (input phase, input sample_point, input cycle_end, input ale, input program_store_read_strobe_n);
endinterface
`default_nettype wire

// *** src/crs_phase_gen.sv ***
// module: twelve-phase machine cycle counter and strobe pattern
`default_nettype none
module crs_phase_gen (
  input  wire logic clk,
  input  wire logic nrst,
  crs_timing_if.gen tim
);
  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  crs_pkg::crs_phase_t phase;
  wire                 last = (phase == crs_pkg::PHASE_LAST);

  function automatic logic in_win(crs_pkg::crs_phase_t ph, crs_pkg::crs_phase_t lo,
                                  crs_pkg::crs_phase_t hi);
    return (ph >= lo) && (ph < hi);
  endfunction

  always_ff @(posedge clk) begin
    if (!nrst)
      phase <= crs_pkg::PHASE_FIRST;
    else
      phase <= last ? crs_pkg::PHASE_FIRST : phase + crs_pkg::PHASE_STEP;
  end

  // ----------------------------------------
  // decoded timing
  // ----------------------------------------
  assign tim.phase        = phase;
  assign tim.cycle_end    = last;
  assign tim.sample_point = (phase == crs_pkg::PHASE_SAMPLE);
  assign tim.ale          = in_win(phase, crs_pkg::ALE_ON_A, crs_pkg::ALE_OFF_A)
                          | in_win(phase, crs_pkg::ALE_ON_B, crs_pkg::ALE_OFF_B);
  assign tim.program_store_read_strobe_n       = !(in_win(phase, crs_pkg::PROGRAM_STORE_READ_STROBE_LO_A, crs_pkg::PROGRAM_STORE_READ_STROBE_HI_A)
                          | in_win(phase, crs_pkg::PROGRAM_STORE_READ_STROBE_LO_B, crs_pkg::PROGRAM_STORE_READ_STROBE_HI_B));
endmodule
`default_nettype wire

// *** src/crs_sequencer.sv ***
// module: cpu reset sequencer with sfr reset loading and strobe control
//
// Contract
// - reset input is asynchronous; sampled once per machine cycle at state 5 phase 2
// - after first high sample, pins keep activity nineteen more oscillator periods
// - while reset is active both strobes are weakly pulled high
// - strobes resume toggling at the first machine cycle boundary after reset is sampled low
// - reset writes zero to all sfrs but port latches, stack pointer, serial buffer, timer 2 without THREE_TIMER, spare priority/enable/power bits
// - port latches load ff, stack pointer 07, serial buffer left alone
// - priority, enable and power control get variant patterns; spare bits untouched
// - internal data ram is never altered by reset
// - port levels undefined until reset has loaded ones into the latches
// - instruction fetch only enabled after a completed reset
`default_nettype none
module crs_sequencer #(
  parameter logic THREE_TIMER = 1'b0,
  parameter logic LOW_POWER   = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       rst_in,
  input  wire logic       addr_latch_strobe_in,
  output var  logic       addr_latch_strobe_out,
  output var  logic       addr_latch_strobe_oe,
  input  wire logic       program_store_read_strobe_n_in,
  output var  logic       program_store_read_strobe_n_out,
  output var  logic       program_store_read_strobe_n_oe,
  output var  logic       strobe_weak_pullup,
  output var  logic       strobe_fault,
  output var  logic       cpu_reset,
  output var  logic       core_run,
  output var  logic       ports_defined,
  input  wire logic       sfr_we,
  input  wire logic [4:0] sfr_idx,
  input  wire logic [7:0] sfr_wdata,
  output var  logic [7:0] sfr_rdata,
  input  wire logic       ram_we,
  input  wire logic [3:0] ram_idx,
  input  wire logic [7:0] ram_wdata,
  output var  logic [7:0] ram_rdata
);
  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  crs_timing_if tim ();

  crs_phase_gen u_phase (
    .clk  (clk),
    .nrst (nrst),
    .tim  (tim)
  );

  // ----------------------------------------
  // reset input sampling and state
  // ----------------------------------------
  crs_pkg::crs_state_t state;
  crs_pkg::crs_state_t next_state;
  crs_pkg::crs_hold_t  hold_count;
  crs_pkg::crs_hold_t  next_hold_count;
  logic                rst_sample;
  logic                reset_done;

  // rst_in is only looked at on the sample phase; no other logic reads it
  wire sample_high = tim.sample_point && rst_in;
  wire sample_low  = tim.sample_point && !rst_in;
  wire hold_over   = (hold_count == crs_pkg::HOLD_DONE);
  wire release_now = (state == crs_pkg::ST_RESET) && tim.cycle_end && !rst_sample;
  wire next_in_rst = (next_state == crs_pkg::ST_RESET);
  wire next_done   = reset_done || release_now;

  always_comb begin
    next_state      = state;
    next_hold_count = hold_count;
    unique case (state)
      crs_pkg::ST_RUN: begin
        if (sample_high) begin
          next_state      = crs_pkg::ST_PEND;
          next_hold_count = crs_pkg::HOLD_LOAD;
        end
      end
      crs_pkg::ST_PEND: begin
        // short pulse: a low sample before the hold ends cancels it
        if (sample_low)
          next_state = crs_pkg::ST_RUN;
        else if (hold_over)
          next_state = crs_pkg::ST_RESET;
        else
          next_hold_count = hold_count - crs_pkg::HOLD_STEP;
      end
      crs_pkg::ST_RESET: begin
        if (release_now)
          next_state = crs_pkg::ST_RUN;
      end
      default: next_state = crs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state      <= crs_pkg::ST_RUN;
      hold_count <= crs_pkg::HOLD_DONE;
      rst_sample <= 1'b0;
      reset_done <= 1'b0;
    end else begin
      state      <= next_state;
      hold_count <= next_hold_count;
      rst_sample <= tim.sample_point ? rst_in : rst_sample;
      reset_done <= next_done;
    end
  end

  // ----------------------------------------
  // reset outputs and strobe pins
  // ----------------------------------------
  wire strobe_forced_low = !addr_latch_strobe_in || !program_store_read_strobe_n_in;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpu_reset                       <= 1'b0;
      core_run                        <= 1'b0;
      addr_latch_strobe_out           <= 1'b1;
      addr_latch_strobe_oe            <= 1'b0;
      program_store_read_strobe_n_out <= 1'b1;
      program_store_read_strobe_n_oe  <= 1'b0;
      strobe_weak_pullup              <= 1'b1;
      strobe_fault                    <= 1'b0;
    end else begin
      cpu_reset                       <= next_in_rst;
      core_run                        <= next_done && !next_in_rst;
      // released drivers plus pull-up; pattern restarts at the boundary
      addr_latch_strobe_out           <= next_in_rst || tim.ale;
      addr_latch_strobe_oe            <= !next_in_rst;
      program_store_read_strobe_n_out <= next_in_rst || tim.program_store_read_strobe_n;
      program_store_read_strobe_n_oe  <= !next_in_rst;
      strobe_weak_pullup              <= next_in_rst;
      // sticky record of a strobe driven low during cpu reset; only nrst clears it
      strobe_fault <= strobe_fault || (cpu_reset && strobe_forced_low);
    end
  end

  // ----------------------------------------
  // special function registers
  // ----------------------------------------
  crs_pkg::crs_byte_t special_function_register [crs_pkg::SFR_COUNT];
  crs_pkg::crs_byte_t ram [crs_pkg::RAM_COUNT];
  logic               sfr_hit;

  // no nrst load here: contents are unknown until a cpu reset runs
  assign sfr_hit = (32'(sfr_idx) < crs_pkg::SFR_COUNT);
  wire sfr_write = sfr_we && !cpu_reset && sfr_hit;

  always_ff @(posedge clk) begin
    for (int i = 0; i < crs_pkg::SFR_COUNT; i++) begin
      if (cpu_reset)
        special_function_register[i] <= (special_function_register[i] & ~crs_pkg::reset_mask(5'(i), THREE_TIMER, LOW_POWER))
                | (crs_pkg::reset_value(5'(i))
                & crs_pkg::reset_mask(5'(i), THREE_TIMER, LOW_POWER));
      else if (sfr_write && (sfr_idx == 5'(i)))
        special_function_register[i] <= sfr_wdata;
    end
  end

  // ----------------------------------------
  // internal data ram
  // ----------------------------------------
  // ram has no reset path at all; writes are held off during reset
  wire ram_write = ram_we && !cpu_reset;

  always_ff @(posedge clk) begin
    if (ram_write)
      ram[ram_idx] <= ram_wdata;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sfr_rdata     <= crs_pkg::VAL_ZERO;
      ram_rdata     <= crs_pkg::VAL_ZERO;
      ports_defined <= 1'b0;
    end else begin
      sfr_rdata     <= sfr_hit ? special_function_register[sfr_idx] : crs_pkg::VAL_ZERO;
      ram_rdata     <= ram[ram_idx];
      ports_defined <= ports_defined || cpu_reset;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_sample_once;
    $changed(rst_sample) |-> $past(tim.sample_point);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("reset sampled off phase");

  property p_port_hold;
    (state == crs_pkg::ST_RUN && sample_high) ##12 sample_high
      |-> (!cpu_reset)[*8] ##1 !cpu_reset ##1 cpu_reset;
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("reset not 19 periods after sample");

  property p_short_pulse;
    (state == crs_pkg::ST_RUN && sample_high) ##12 sample_low |=> !cpu_reset;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("single sample caused reset");

  property p_pull_high;
    cpu_reset |-> strobe_weak_pullup && addr_latch_strobe_out && !addr_latch_strobe_oe
      && program_store_read_strobe_n_out && !program_store_read_strobe_n_oe;
  endproperty
  a_pull_high: assert property (p_pull_high) else $error("strobe driven during reset");

  property p_resume;
    (cpu_reset && sample_low) |-> ##[3:12] (addr_latch_strobe_oe && addr_latch_strobe_out);
  endproperty
  a_resume: assert property (p_resume) else $error("strobes late after release");

  property p_release;
    $fell(cpu_reset) |-> tim.phase == crs_pkg::PHASE_FIRST && !rst_sample;
  endproperty
  a_release: assert property (p_release) else $error("release off boundary");

  property p_hold_while_high;
    cpu_reset && rst_sample |=> cpu_reset;
  endproperty
  a_hold_while_high: assert property (p_hold_while_high) else $error("reset dropped early");

  property p_zero_load;
    $past(cpu_reset) |-> special_function_register[crs_pkg::IDX_PCL] == crs_pkg::VAL_ZERO
      && special_function_register[crs_pkg::IDX_ACC] == crs_pkg::VAL_ZERO && special_function_register[crs_pkg::IDX_SERIAL_CONTROL_REGISTER] == crs_pkg::VAL_ZERO;
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("sfr not cleared");

  property p_port_sp_load;
    $past(cpu_reset) |-> special_function_register[crs_pkg::IDX_P0] == crs_pkg::VAL_PORT
      && special_function_register[crs_pkg::IDX_P3] == crs_pkg::VAL_PORT && special_function_register[crs_pkg::IDX_SP] == crs_pkg::VAL_SP;
  endproperty
  a_port_sp_load: assert property (p_port_sp_load) else $error("port or stack value wrong");

  property p_serial_buffer_kept;
    cpu_reset |=> $stable(special_function_register[crs_pkg::IDX_SERIAL_BUFFER]);
  endproperty
  a_serial_buffer_kept: assert property (p_serial_buffer_kept) else $error("serial buffer touched");

  property p_ie_pattern;
    $past(cpu_reset) |-> (special_function_register[crs_pkg::IDX_IE]
      & crs_pkg::reset_mask(crs_pkg::IDX_IE, THREE_TIMER, LOW_POWER)) == crs_pkg::VAL_ZERO;
  endproperty
  a_ie_pattern: assert property (p_ie_pattern) else $error("enable pattern wrong");

  property p_ram_kept;
    // two reset cycles in a row so no write or index change can slip in
    $past(cpu_reset) && cpu_reset && $stable(ram_idx) ##1 $stable(ram_idx) |-> $stable(ram_rdata);
  endproperty
  a_ram_kept: assert property (p_ram_kept) else $error("ram changed in reset");

  property p_run_after_reset;
    $rose(core_run) |-> $past(cpu_reset) && ports_defined;
  endproperty
  a_run_after_reset: assert property (p_run_after_reset) else $error("run without reset");

  c_full_reset: cover property ($rose(cpu_reset));
  c_release:    cover property ($fell(cpu_reset) ##[3:12] addr_latch_strobe_out);
  c_cancel:     cover property ((state == crs_pkg::ST_PEND) ##1 (state == crs_pkg::ST_RUN));
  c_fault:      cover property ($rose(strobe_fault));
endmodule
`default_nettype wire

// *** sim/crs_reset_src.sv ***
// partner: external reset source and strobe pin wiring
`default_nettype none
module crs_reset_src (
  input  wire logic clk,
  input  wire logic rst_level,
  input  wire logic pull_low,
  input  wire logic ale_out,
  input  wire logic ale_oe,
  input  wire logic program_store_read_strobe_out,
  input  wire logic program_store_read_strobe_oe,
  input  wire logic weak_pullup,
  output var  logic rst_in,
  output var  logic ale_pin,
  output var  logic program_store_read_strobe_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ale_last;
  logic program_store_read_strobe_last;
  // ----------------------------------------
  // reset pin and strobe pin resolution
  // ----------------------------------------
  assign rst_in = rst_level;
  // pulling low only on command, never by default
  assign ale_pin  = ale_oe ? ale_out : pull_low ? 1'b0 : weak_pullup ? 1'b1 : ~ale_last;
  assign program_store_read_strobe_pin = program_store_read_strobe_oe ? program_store_read_strobe_out : pull_low ? 1'b0 : weak_pullup ? 1'b1 : ~program_store_read_strobe_last;
  always_ff @(posedge clk) begin
    ale_last  <= ale_pin;
    program_store_read_strobe_last <= program_store_read_strobe_pin;
  end
endmodule
`default_nettype wire

// *** sim/cpu_reset_sequencer_bench.sv ***
// bench: self-checking scenarios for the reset sequencer
`default_nettype none
module cpu_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, nrst, rst_level, pull_low, rst_in, ale_pin, program_store_read_strobe_pin;
  logic       ale_out, ale_oe, program_store_read_strobe_out, program_store_read_strobe_oe, weak_pullup, strobe_fault;
  logic       cpu_reset, core_run, ports_defined, sfr_we, ram_we, watch, seen;
  logic [4:0] sfr_idx;
  logic [3:0] ram_idx, ph;
  logic [7:0] sfr_wdata, sfr_rdata, ram_wdata, ram_rdata;
  int         n_errors, compares, cyc;

  crs_sequencer dut (
    .clk(clk), .nrst(nrst), .rst_in(rst_in),
    .addr_latch_strobe_in(ale_pin), .addr_latch_strobe_out(ale_out), .addr_latch_strobe_oe(ale_oe),
    .program_store_read_strobe_n_in(program_store_read_strobe_pin), .program_store_read_strobe_n_out(program_store_read_strobe_out),
    .program_store_read_strobe_n_oe(program_store_read_strobe_oe), .strobe_weak_pullup(weak_pullup),
    .strobe_fault(strobe_fault), .cpu_reset(cpu_reset), .core_run(core_run),
    .ports_defined(ports_defined), .sfr_we(sfr_we), .sfr_idx(sfr_idx), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .ram_we(ram_we), .ram_idx(ram_idx), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata)
  );
  crs_reset_src src (
    .clk(clk), .rst_level(rst_level), .pull_low(pull_low), .ale_out(ale_out), .ale_oe(ale_oe),
    .program_store_read_strobe_out(program_store_read_strobe_out), .program_store_read_strobe_oe(program_store_read_strobe_oe), .weak_pullup(weak_pullup), .rst_in(rst_in),
    .ale_pin(ale_pin), .program_store_read_strobe_pin(program_store_read_strobe_pin)
  );
  // ----------------------------------------
  // clock, phase mirror, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ph <= (!nrst || ph == 4'hb) ? 4'h0 : ph + 4'h1;
    if (watch && cpu_reset === 1'b1) seen <= 1'b1;
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // leaves the caller just after the edge that brings the phase to p
  task automatic sync(input logic [3:0] p);
    do begin
      @(posedge clk);
      #1;
    end while (ph !== p);
  endtask
  task automatic drive_rst(input logic v);
    sync(4'h8);
    @(posedge clk) rst_level <= v;
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d, input logic to_ram);
    @(posedge clk);
    sfr_we <= !to_ram; ram_we <= to_ram; sfr_idx <= i; ram_idx <= i[3:0];
    sfr_wdata <= d; ram_wdata <= d;
    @(posedge clk);
    sfr_we <= 1'b0; ram_we <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] i);
    @(posedge clk);
    sfr_idx <= i; ram_idx <= i[3:0];
    @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] exp_sfr(input int i);
    case (i)
      5: return 8'h07;
      8, 9, 10, 11, 20, 21, 22, 23, 25: return 8'hff;
      12: return 8'he0;
      13: return 8'h60;
      26: return 8'h7f;
      default: return 8'h00;
    endcase
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_before;
    #1;
    chk({7'h00, ports_defined}, 8'h00, "ports defined early");
    chk({7'h00, core_run}, 8'h00, "run before reset");
    for (int i = 0; i < 32; i++) wr(5'(i), 8'hff, 1'b0);
    for (int i = 0; i < 16; i++) wr(5'(i), 8'(i * 17), 1'b1);
  endtask
  task automatic t_short;
    watch = 1'b1;
    drive_rst(1'b1);
    repeat (12) @(posedge clk);
    rst_level <= 1'b0;
    sync(4'h9);
    @(posedge clk) rst_level <= 1'b1;
    repeat (10) @(posedge clk);
    rst_level <= 1'b0;
    repeat (40) @(posedge clk);
    watch = 1'b0;
    chk({7'h00, seen}, 8'h00, "short pulse reset");
  endtask
  task automatic t_assert;
    drive_rst(1'b1);
    repeat (20) @(posedge clk);
    #1 chk({7'h00, cpu_reset}, 8'h00, "reset early");
    chk({7'h00, ale_oe}, 8'h01, "activity cut early");
    @(posedge clk);
    #1 chk({7'h00, cpu_reset}, 8'h01, "reset late");
    chk({4'h0, weak_pullup, ale_oe, program_store_read_strobe_oe, core_run}, 8'h08, "strobe drive in reset");
    chk({6'h00, ale_pin, program_store_read_strobe_pin}, 8'h03, "strobe pins in reset");
    wr(5'h02, 8'h55, 1'b0);
    wr(5'h00, 8'haa, 1'b1);
    repeat (30) @(posedge clk);
    #1 chk({6'h00, cpu_reset, ports_defined}, 8'h03, "reset held or ports");
  endtask
  task automatic t_release;
    drive_rst(1'b0);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, cpu_reset}, 8'h01, "released early");
    @(posedge clk);
    #1 chk({4'h0, cpu_reset, core_run, ale_oe, weak_pullup}, 8'h06, "release state");
    repeat (2) @(posedge clk);
    #1 chk({7'h00, ale_out}, 8'h01, "strobe not toggling");
    repeat (3) @(posedge clk);
    #1 chk({7'h00, program_store_read_strobe_out}, 8'h00, "read strobe not toggling");
  endtask
  task automatic t_readback;
    for (int i = 0; i < 32; i++) begin
      rd(5'(i));
      chk(sfr_rdata, exp_sfr(i), "sfr reset value");
      if (i < 16) chk(ram_rdata, 8'(i * 17), "ram changed");
    end
    wr(5'h02, 8'h5a, 1'b0);
    rd(5'h02);
    chk(sfr_rdata, 8'h5a, "write after reset");
  endtask
  task automatic t_fault;
    drive_rst(1'b1);
    repeat (24) @(posedge clk);
    #1 chk({7'h00, strobe_fault}, 8'h00, "fault too soon");
    @(posedge clk) pull_low <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, strobe_fault}, 8'h01, "fault not seen");
    @(posedge clk) pull_low <= 1'b0;
    drive_rst(1'b0);
    repeat (6) @(posedge clk);
    #1 chk({6'h00, cpu_reset, strobe_fault}, 8'h01, "fault state");
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0; rst_level = 1'b0; pull_low = 1'b0; sfr_we = 1'b0; ram_we = 1'b0;
    sfr_idx = 5'h00; ram_idx = 4'h0; sfr_wdata = 8'h00; ram_wdata = 8'h00;
    watch = 1'b0; seen = 1'b0; n_errors = 0; compares = 0; cyc = 0; ph = 4'h0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_before;
    t_short;
    t_assert;
    t_release;
    t_readback;
    t_fault;
    tally_and_finish;
  end
endmodule
`default_nettype wire
